// [verilog/spi_serial_map.svh]
// Purpose: register offsets, field positions, reset values and codes
// Assumes: 8-bit registers on a 2-bit register address
// Notes: definitions only
`ifndef SPI_SERIAL_MAP_SVH
`define SPI_SERIAL_MAP_SVH
`define MODE_CTRL_OFS 2'h0
`define FORMAT_CTRL_OFS 2'h1
`define SHIFT_DATA_OFS 2'h2
`define MODE_CTRL_RST 8'he0
`define FORMAT_CTRL_RST 8'h00
`define SHIFT_DATA_RST 8'h00
`define MODE_FIELD_HI 7
`define MODE_FIELD_LO 5
`define UNIMPL_BIT 4
`define ENABLE_BIT 1
`define INCOMPLETE_BIT 0
`define DONE_BIT 0
`define COLLISION_BIT 1
`define MODE_DIV4 3'h0
`define MODE_DIV16 3'h1
`define MODE_DIV64 3'h2
`define MODE_SUB_CLK 3'h3
`define MODE_TIMER 3'h4
`define MODE_SLAVE 3'h5
`define HALF_DIV4 6'h02
`define HALF_DIV16 6'h08
`define HALF_DIV64 6'h20
`define LEAD_CYCLES 2'h3
`define LAST_EDGE 4'hf
`endif

// [verilog/spi_serial_pkg.sv]
// Purpose: shared types of the serial interface
// Assumes: field layout of the format control register
// Notes: constants live in spi_serial_map.svh
package spi_serial_pkg;
  typedef enum logic {IDLE_ST, SHIFT_ST} xfer_state_e;
  // format control register, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] spare;
    logic clock_idle_polarity;
    logic clock_active_edge_select;
    logic bit_order_select;
    logic select_pin_enable;
    logic write_collision_flag;
    logic transfer_done_flag;
  } format_s;
endpackage

// [verilog/spi_serial_interface.sv]
// Purpose: SPI personality of the shared serial interface, master and slave
// Assumes: serial clock far slower than core_clk_in in slave mode
// Notes: sck, sdi, scs and the sub clock pass two flops before use
// How it works
// - modes 000/001/010 are master with serial clock at core clock /4, /16, /64.
// - mode 011 masters from sub clock, 100 at half the timer match rate.
// - 101 is slave, 110 two-wire slave (absent here), 111 does nothing.
// - slave never drives the serial clock, shifts on external edges only.
// - master starts every transfer and drives clock; slave only responds.
// - enable low releases all pins and stops all activity.
// - enabling keeps every control register as it was.
// - select enable makes the select pin work; otherwise it floats.
// - slave deselected mid-byte sets incomplete flag and done flag.
// - incomplete flag raises the interrupt request.
// - software writing incomplete flag does not set done flag.
// - one 8-bit shift data register holds sent and received bytes.
// - mode register bit 4 ignores writes and reads zero.
// - master write to shift data starts an 8-bit exchange at once.
// - each finished byte sets done flag; only software clears it.
// - write during a transfer is dropped and sets collision flag.
// - slave with select disabled is always active, ignores select pin.
`timescale 1ns/1ps
`include "spi_serial_map.svh"
module spi_serial_interface (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sub_clk_in,
  input wire logic timer0_match_in,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  input wire logic slave_select_n_in,
  output logic slave_select_n_out,
  output logic slave_select_n_oe_out,
  output logic irq_req_out
);

  // reset release through two flops
  logic rst_s1_ff, rst_n_ff;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  logic [7:0] mode_ctrl_ff, shift_ff, reg_rdata_ff;
  spi_serial_pkg::format_s fmt_ff;
  spi_serial_pkg::xfer_state_e state_ff;
  logic [3:0] edge_cnt_ff;
  logic [5:0] div_cnt_ff;
  logic [1:0] lead_cnt_ff;
  logic sample_ff, sck_ff, sdo_ff, scs_n_ff;

  // pin synchronisers; first stage feeds only the second
  logic sck_s1_ff, sck_s_ff, sck_d_ff, sdi_s1_ff, sdi_s_ff;
  logic scs_s1_ff, scs_s_ff, scs_d_ff, sub_s1_ff, sub_s_ff, sub_d_ff;
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      {sck_s1_ff, sck_s_ff, sck_d_ff} <= 3'h0;
      {sdi_s1_ff, sdi_s_ff} <= 2'h0;
      {scs_s1_ff, scs_s_ff, scs_d_ff} <= 3'h7;
      {sub_s1_ff, sub_s_ff, sub_d_ff} <= 3'h0;
    end else begin
      sck_s1_ff <= sck_in;
      sck_s_ff <= sck_s1_ff;
      sck_d_ff <= sck_s_ff;
      sdi_s1_ff <= sdi_in;
      sdi_s_ff <= sdi_s1_ff;
      scs_s1_ff <= slave_select_n_in;
      scs_s_ff <= scs_s1_ff;
      scs_d_ff <= scs_s_ff;
      sub_s1_ff <= sub_clk_in;
      sub_s_ff <= sub_s1_ff;
      sub_d_ff <= sub_s_ff;
    end
  end

  // half period of the divided core clock, in core cycles
  function automatic logic [5:0] half_len(input logic [2:0] m);
    case (m)
      `MODE_DIV4: half_len = `HALF_DIV4;
      `MODE_DIV16: half_len = `HALF_DIV16;
      default: half_len = `HALF_DIV64;
    endcase
  endfunction

  // one shift step in the chosen bit order
  function automatic logic [7:0] shift_step(input logic [7:0] d, input logic b,
                                            input logic msb);
    shift_step = msb ? {d[6:0], b} : {b, d[7:1]};
  endfunction

  // mode decode
  logic [2:0] mode;
  logic enabled, is_master, is_slave, spi_on, slave_sel, slave_act;
  assign mode = mode_ctrl_ff[`MODE_FIELD_HI:`MODE_FIELD_LO];
  assign enabled = mode_ctrl_ff[`ENABLE_BIT];
  assign is_master = (mode <= `MODE_TIMER);
  assign is_slave = (mode == `MODE_SLAVE);
  assign spi_on = enabled && (is_master || is_slave);
  // select disabled: slave listens regardless of the pin
  assign slave_sel = !fmt_ff.select_pin_enable || !scs_s_ff;
  assign slave_act = spi_on && is_slave && slave_sel;

  // master bit-rate tick by source
  logic tick;
  always_comb begin
    case (mode)
      `MODE_DIV4, `MODE_DIV16, `MODE_DIV64: tick = (div_cnt_ff == half_len(mode) - 6'h01);
      `MODE_SUB_CLK: tick = sub_s_ff ^ sub_d_ff; // each sub clock edge is a half period
      `MODE_TIMER: tick = timer0_match_in; // each match toggles, so sck = rate / 2
      default: tick = 1'b0;
    endcase
  end

  // serial clock edges: own ticks in master, pin edges in slave
  logic m_edge, s_edge, edge_ev, lead, capt, last, do_shift, done_ev;
  assign m_edge = spi_on && is_master && (state_ff == spi_serial_pkg::SHIFT_ST) && tick &&
                  (lead_cnt_ff == `LEAD_CYCLES);
  assign s_edge = slave_act && (sck_s_ff != sck_d_ff);
  assign edge_ev = m_edge || s_edge;
  assign lead = !edge_cnt_ff[0];
  // capture on leading edge when edge select is set, else on trailing
  assign capt = lead ? fmt_ff.clock_active_edge_select : !fmt_ff.clock_active_edge_select;
  assign last = (edge_cnt_ff == `LAST_EDGE);
  // the sixteenth edge always closes the byte, whichever kind it is
  assign do_shift = edge_ev && (last || (!capt && edge_cnt_ff != 4'h0));
  assign done_ev = edge_ev && last;

  // register bus events
  logic data_wr, busy, start, collide, scs_rise, abort_ev;
  assign data_wr = reg_wr_in && (reg_addr_in == `SHIFT_DATA_OFS);
  assign busy = is_master ? (state_ff == spi_serial_pkg::SHIFT_ST) : (edge_cnt_ff != 4'h0);
  assign start = data_wr && spi_on && is_master && !busy;
  assign collide = data_wr && spi_on && busy;
  assign scs_rise = scs_s_ff && !scs_d_ff;
  assign abort_ev = spi_on && is_slave && fmt_ff.select_pin_enable && scs_rise &&
                    (edge_cnt_ff != 4'h0);

  // master transfer state
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= spi_serial_pkg::IDLE_ST;
    end else if (!spi_on) begin
      state_ff <= spi_serial_pkg::IDLE_ST;
    end else if (start) begin
      state_ff <= spi_serial_pkg::SHIFT_ST;
    end else if (m_edge && last) begin
      state_ff <= spi_serial_pkg::IDLE_ST;
    end
  end

  // divider restarts at each transfer so the first half period is full
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      div_cnt_ff <= 6'h00;
    end else if (state_ff != spi_serial_pkg::SHIFT_ST || tick) begin
      div_cnt_ff <= 6'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 6'h01;
    end
  end

  // select low settles through the far side and our input flops before the first
  // edge; without it a fast or free-running rate captures the stale line level
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      lead_cnt_ff <= 2'h0;
    end else if (state_ff != spi_serial_pkg::SHIFT_ST) begin
      lead_cnt_ff <= 2'h0;
    end else if (lead_cnt_ff != `LEAD_CYCLES) begin
      lead_cnt_ff <= lead_cnt_ff + 2'h1;
    end
  end

  // edge counter; deselect or disable drops a partial byte
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      edge_cnt_ff <= 4'h0;
    end else if (!spi_on || abort_ev || (is_slave && !slave_sel) || start) begin
      edge_cnt_ff <= 4'h0;
    end else if (edge_ev) begin
      edge_cnt_ff <= edge_cnt_ff + 4'h1;
    end
  end

  // input sample on the capture edge
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sample_ff <= 1'b0;
    end else if (edge_ev && capt) begin
      sample_ff <= sdi_s_ff;
    end
  end

  // shift data: software load when idle, else serial shifting
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      shift_ff <= `SHIFT_DATA_RST;
    end else if (data_wr && !collide) begin
      shift_ff <= reg_wdata_in;
    end else if (do_shift) begin
      // last edge of a trailing-capture byte takes the live input bit
      shift_ff <= shift_step(shift_ff, capt ? sdi_s_ff : sample_ff,
                             fmt_ff.bit_order_select);
    end
  end

  // serial clock out: idle level is the inverse of the polarity bit, toggles per tick
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sck_ff <= 1'b1;
    end else if (state_ff != spi_serial_pkg::SHIFT_ST) begin
      sck_ff <= !fmt_ff.clock_idle_polarity;
    end else if (m_edge) begin
      sck_ff <= !sck_ff;
    end
  end

  // data out registered; follows a fresh write at once
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sdo_ff <= 1'b1;
      scs_n_ff <= 1'b1;
    end else begin
      sdo_ff <= fmt_ff.bit_order_select ? shift_ff[7] : shift_ff[0];
      scs_n_ff <= !(state_ff == spi_serial_pkg::SHIFT_ST); // select only while shifting
    end
  end

  // mode register; enabling reloads nothing, software sets it up
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mode_ctrl_ff <= `MODE_CTRL_RST;
    end else begin
      if (reg_wr_in && reg_addr_in == `MODE_CTRL_OFS) begin
        mode_ctrl_ff <= reg_wdata_in;
        mode_ctrl_ff[`UNIMPL_BIT] <= 1'b0;
        mode_ctrl_ff[`INCOMPLETE_BIT] <= reg_wdata_in[`INCOMPLETE_BIT] || abort_ev;
      end else if (abort_ev) begin
        mode_ctrl_ff[`INCOMPLETE_BIT] <= 1'b1;
      end
    end
  end

  // format register; hardware set of a flag beats a software clear
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      fmt_ff <= `FORMAT_CTRL_RST;
    end else begin
      if (reg_wr_in && reg_addr_in == `FORMAT_CTRL_OFS) begin
        fmt_ff <= reg_wdata_in;
        fmt_ff.transfer_done_flag <= reg_wdata_in[`DONE_BIT] || done_ev || abort_ev;
        fmt_ff.write_collision_flag <= reg_wdata_in[`COLLISION_BIT] || collide;
      end else begin
        if (done_ev || abort_ev) begin
          fmt_ff.transfer_done_flag <= 1'b1;
        end
        if (collide) begin
          fmt_ff.write_collision_flag <= 1'b1;
        end
      end
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `MODE_CTRL_OFS: reg_rdata_ff <= mode_ctrl_ff; // bit 4 kept zero
        `FORMAT_CTRL_OFS: reg_rdata_ff <= fmt_ff;
        `SHIFT_DATA_OFS: reg_rdata_ff <= shift_ff;
        default: reg_rdata_ff <= 8'h00;
      endcase
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  // pin drive; all released while disabled
  assign reg_rdata_out = reg_rdata_ff;
  assign sck_out = sck_ff;
  assign sck_oe_out = spi_on && is_master;
  assign sdo_out = sdo_ff;
  assign sdo_oe_out = spi_on && (is_master || slave_act);
  assign slave_select_n_out = scs_n_ff; // one select only; more need general pins
  assign slave_select_n_oe_out = spi_on && is_master && fmt_ff.select_pin_enable;
  // gating by the interrupt enable happens in the interrupt controller
  assign irq_req_out = fmt_ff.transfer_done_flag || mode_ctrl_ff[`INCOMPLETE_BIT];

  default clocking dc @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_ff);

  sequence div4_run_s;
    (state_ff == spi_serial_pkg::SHIFT_ST) && spi_on && (mode == `MODE_DIV4) && tick;
  endsequence
  sequence abort_s;
    abort_ev;
  endsequence

  div4_rate_a: assert property (div4_run_s |=> !tick ##1 (tick || !busy))
    else $error("divide by 4 tick spacing wrong");
  slave_no_clk_a: assert property (is_slave |-> !sck_oe_out)
    else $error("slave drives serial clock");
  disabled_pins_a: assert property (!enabled |-> !sck_oe_out && !sdo_oe_out &&
                                    !slave_select_n_oe_out)
    else $error("pin driven while disabled");
  unused_mode_a: assert property (mode[2:1] == 2'h3 |-> !sdo_oe_out && !busy)
    else $error("unused mode is active");
  abort_flags_a: assert property (abort_s |=> mode_ctrl_ff[`INCOMPLETE_BIT] &&
                                  fmt_ff.transfer_done_flag ##0 irq_req_out)
    else $error("abort did not set both flags");
  sw_incomplete_a: assert property (reg_wr_in && reg_addr_in == `MODE_CTRL_OFS &&
                                    reg_wdata_in[0] && !fmt_ff.transfer_done_flag &&
                                    !done_ev && !abort_ev |=> !fmt_ff.transfer_done_flag)
    else $error("software write set done flag");
  bit4_zero_a: assert property (reg_rd_in && reg_addr_in == `MODE_CTRL_OFS |=>
                                !reg_rdata_out[`UNIMPL_BIT])
    else $error("unimplemented bit reads one");
  write_start_a: assert property (start |=> busy ##1 $stable(busy))
    else $error("master write did not start");
  collision_a: assert property (collide |=> fmt_ff.write_collision_flag &&
                                $stable(shift_ff))
    else $error("collision not flagged or data lost");
  byte_done_a: assert property (done_ev |=> fmt_ff.transfer_done_flag &&
                                edge_cnt_ff == 4'h0)
    else $error("byte end mishandled");
  select_float_a: assert property (!fmt_ff.select_pin_enable |-> !slave_select_n_oe_out)
    else $error("select pin driven while disabled");

endmodule // spi_serial_interface

// [dv/spi_peer_model.sv]
// Purpose: external SPI slave facing the block while it is master
// Assumes: msb first; return byte is set on tx_in before select falls
// Notes: a released data line shows the inverse of its last bit
`timescale 1ns/1ps
module spi_peer_model (
  input wire logic sck_in,
  input wire logic select_n_in,
  input wire logic sdo_in,
  input wire logic cap_rise_in,
  input wire logic [7:0] tx_in,
  output logic miso_out,
  output logic [7:0] rx_out
);
  logic [7:0] tx_sr;
  initial begin
    miso_out = 1'b1;
    rx_out = 8'h00;
    tx_sr = 8'h00;
  end
  // first bit waits on the line before any clock edge
  always @(negedge select_n_in) begin
    tx_sr = tx_in;
    miso_out = tx_in[7];
  end
  // a stale bit here must not pass for data
  always @(posedge select_n_in) miso_out = ~miso_out;
  // shifts only on edges the master makes
  always @(sck_in) begin
    if (!select_n_in && sck_in === cap_rise_in) begin
      rx_out = {rx_out[6:0], sdo_in};
      tx_sr = {tx_sr[6:0], 1'b0};
      miso_out = tx_sr[7];
    end
  end
endmodule // spi_peer_model

// [dv/spi_serial_interface_bench.sv]
// Purpose: self-checking bench of the serial interface, master and slave
// Assumes: seed 25; sub clock edge every 4 cycles, timer pulse every 5
// Notes: peer is msb first only, so lsb-first order is not exercised
`timescale 1ns/1ps
`include "spi_serial_map.svh"
module spi_serial_interface_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, peer_tx, peer_rx;
  logic wr_s, rd_s, sub_clk, tmr, tb_sck, tb_sdi, tb_ss, slv_mode, cap_rise;
  logic sck_out, sck_oe, sdo, sdo_oe, ss_out, ss_oe, irq, miso, sck_q;
  logic ss_seen;
  int err_total, compares, tog;
  wire logic sck_line = sck_oe ? sck_out : tb_sck;
  // a single peer on the one select pin; more peers would need general pins
  wire logic ss_line = ss_oe ? ss_out : tb_ss;
  wire logic sdi_line = slv_mode ? tb_sdi : miso;
  spi_serial_interface u_dut (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .sub_clk_in(sub_clk), .timer0_match_in(tmr), .sck_in(sck_line), .sck_out(sck_out),
    .sck_oe_out(sck_oe), .sdi_in(sdi_line), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .slave_select_n_in(ss_line), .slave_select_n_out(ss_out),
    .slave_select_n_oe_out(ss_oe), .irq_req_out(irq));
  spi_peer_model u_peer (.sck_in(sck_line), .select_n_in(ss_line), .sdo_in(sdo),
    .cap_rise_in(cap_rise), .tx_in(peer_tx), .miso_out(miso), .rx_out(peer_rx));
  always #2.5 clk = ~clk;
  // edge count and select watch, so a short byte cannot hide
  always @(posedge clk) begin
    sck_q <= sck_out;
    if (sck_q !== sck_out) tog++;
    if (ss_oe === 1'b1 && ss_out === 1'b0) ss_seen = 1'b1;
  end
  // sub clock and timer match run free, as their sources would
  always begin
    repeat (4) @(posedge clk);
    sub_clk <= ~sub_clk;
  end
  always begin
    repeat (4) @(posedge clk);
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
  end
  // expected sck half period in core cycles for each master mode
  function automatic int half_of(input logic [2:0] m);
    case (m)
      `MODE_DIV4: return `HALF_DIV4;
      `MODE_DIV16: return `HALF_DIV16;
      `MODE_DIV64: return `HALF_DIV64;
      `MODE_SUB_CLK: return 4;
      default: return 5;
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  // one master byte with a colliding second write
  task automatic mxfer(input logic [2:0] m, input logic [7:0] f, input logic [7:0] d);
    int n, t0, h;
    logic [7:0] v;
    h = half_of(m);
    slv_mode <= 1'b0;
    cap_rise <= (f[5] == f[4]);
    peer_tx <= 8'($urandom);
    wr(`FORMAT_CTRL_OFS, f);
    wr(`MODE_CTRL_OFS, {m, 5'h02});
    // an idle-level change from the new polarity must reach tog before the snapshot
    repeat (2) @(posedge clk);
    t0 = tog;
    ss_seen = 1'b0;
    wr(`SHIFT_DATA_OFS, d);
    wr(`SHIFT_DATA_OFS, ~d);
    n = 2;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk(8'(n >= 16 * h - 2 && n <= 17 * h + 12), 8'h01, "byte length");
    repeat (6) @(posedge clk);
    chk(8'(tog - t0), 8'h10, "sck edges");
    chk(peer_rx, d, "peer received");
    chk(sck_out, {7'h00, ~f[5]}, "sck idle level");
    chk(ss_seen, 1'b1, "select driven");
    rd(`FORMAT_CTRL_OFS, v);
    chk(v, f | 8'h03, "done and collision");
    rd(`SHIFT_DATA_OFS, v);
    chk(v, peer_tx, "master received");
    wr(`FORMAT_CTRL_OFS, f);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "flags cleared");
  endtask
  // slave byte of nb bits; select pin follows select enable
  task automatic sxfer(input logic [7:0] f, input int nb);
    logic [7:0] d, tx, got, v;
    d = 8'($urandom);
    tx = 8'($urandom);
    got = 8'h00;
    slv_mode <= 1'b1;
    wr(`FORMAT_CTRL_OFS, f);
    wr(`MODE_CTRL_OFS, 8'ha2);
    wr(`SHIFT_DATA_OFS, tx);
    tb_ss <= ~f[2];
    repeat (8) @(posedge clk);
    chk(sck_oe, 1'b0, "slave sck drive");
    chk(sdo_oe, 1'b1, "slave sdo drive");
    for (int i = 0; i < nb; i++) begin
      tb_sck <= 1'b0;
      tb_sdi <= d[7 - i];
      repeat (8) @(posedge clk);
      got[7 - i] = sdo;
      tb_sck <= 1'b1;
      repeat (8) @(posedge clk);
    end
    tb_ss <= 1'b1;
    tb_sdi <= ~tb_sdi;
    repeat (10) @(posedge clk);
    rd(`FORMAT_CTRL_OFS, v);
    chk(v, f | 8'h01, "slave done");
    rd(`MODE_CTRL_OFS, v);
    chk(v, (nb == 8) ? 8'ha2 : 8'ha3, "incomplete flag");
    chk(irq, 1'b1, "slave request");
    if (nb == 8) begin
      rd(`SHIFT_DATA_OFS, v);
      chk(v, d, "slave received");
      chk(got, tx, "slave sent");
    end
    wr(`MODE_CTRL_OFS, 8'ha2);
    wr(`FORMAT_CTRL_OFS, f);
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
  initial begin
    logic [7:0] v;
    {addr, wdata, wr_s, rd_s, sub_clk, tmr, tb_sck, tb_sdi} = '0;
    {tb_sck, tb_ss, slv_mode, cap_rise, peer_tx, sck_q} = {4'hf, 8'h00, 1'b1};
    v = 8'($urandom(25));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`MODE_CTRL_OFS, v);
    chk(v, `MODE_CTRL_RST, "mode reset");
    rd(`FORMAT_CTRL_OFS, v);
    chk(v, `FORMAT_CTRL_RST, "format reset");
    rd(`SHIFT_DATA_OFS, v);
    chk(v, `SHIFT_DATA_RST, "data reset");
    wr(2'h3, 8'h5a);
    rd(2'h3, v);
    chk(v, 8'h00, "unmapped");
    wr(`MODE_CTRL_OFS, 8'hff);
    rd(`MODE_CTRL_OFS, v);
    chk(v, 8'hef, "bit 4 reads zero");
    rd(`FORMAT_CTRL_OFS, v);
    chk(v, 8'h00, "software flag no done");
    chk({sck_oe, sdo_oe}, 8'h00, "unused mode");
    wr(`MODE_CTRL_OFS, 8'hc2);
    repeat (4) @(posedge clk);
    chk({sck_oe, sdo_oe}, 8'h00, "two-wire mode");
    wr(`MODE_CTRL_OFS, 8'h20);
    wr(`FORMAT_CTRL_OFS, 8'h2c);
    wr(`SHIFT_DATA_OFS, 8'h3c);
    repeat (40) @(posedge clk);
    chk({sck_oe, sdo_oe, ss_oe, irq}, 8'h00, "disabled pins");
    wr(`MODE_CTRL_OFS, 8'h22);
    rd(`FORMAT_CTRL_OFS, v);
    chk(v, 8'h2c, "format kept");
    rd(`SHIFT_DATA_OFS, v);
    chk(v, 8'h3c, "data kept");
    chk({sck_oe, sck_out}, 8'h02, "master idle drive");
    for (int m = 0; m < 5; m++) begin
      repeat (2) mxfer(3'(m), {2'b00, 1'($urandom), 1'($urandom), 4'hc}, 8'($urandom));
    end
    sxfer(8'h0c, 8);
    sxfer(8'h0c, 3);
    sxfer(8'h08, 8);
    report_and_stop();
  end
endmodule // spi_serial_interface_bench
